// file: hw/nab_alu.sv
// Purpose: 4-bit alu with binary/decimal arithmetic and skip logic
// Assumes: sequencer holds operands valid while exec_i is high
// Notes: one request per two cycles; busy requests are ignored
//
// Behaviour
// - decimal flag clear gives plain binary add and subtract
// - decimal flag set gives decimal corrected add and subtract
// - binary result is value mod 16, carry on overflow or borrow
// - decimal sums 10..19 give carry and sum minus ten
// - decimal sums of twenty or more give carry and codes 1010 up
// - decimal differences outside -10..9 give carry and fixed codes
// - operands are latched into temporary registers a and b first
// - first operand from register or memory, second memory or immediate
// - rotate uses only the first operand, a general register
// - arithmetic, logic and rotate write back to first operand
// - bit and compare tests write nothing and decide a skip
// - arithmetic obeys both decimal and no-store flags
// - logic ignores mode flags and keeps zero and carry
// - every bit test clears the no-store flag
// - add, add with carry, subtract, subtract with borrow exist
// - arithmetic forms are register-memory or memory-immediate
// - no-store decides write back whatever the decimal mode
// - no-store set suppresses write back but flags still update
// - zero set on 0000, kept on 0000 under no-store, else cleared
// - carry variants inject the carry flag as least significant input
// - rotate puts old carry in bit 3 and bit 0 into carry
`timescale 1ns/1ns
`default_nettype none
module nab_alu #(
  parameter int DATA_W = nab_pkg::DATA_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // instruction request
  input wire logic exec_i,
  input wire nab_pkg::nab_op_t op_i,
  input wire nab_pkg::nab_form_t form_i,
  input wire logic [3:0] gr_data_i,
  input wire logic [3:0] mem_data_i,
  input wire logic [3:0] immediate_nibble_i,
  // direct status word write
  input wire logic psw_wr_i,
  input wire logic [3:0] psw_wdata_i,
  // results
  output logic done_o,
  output logic wb_gr_o,
  output logic wb_mem_o,
  output logic [3:0] wb_data_o,
  output logic skip_o,
  // program_status_word flags
  output logic [3:0] program_status_word_o
);
  // ***********************************
  // elaboration check
  // ***********************************
  if (DATA_W != 4) begin : g_width_check
    $error("nab_alu serves only a 4-bit data path");
  end

  typedef enum logic {ST_IDLE, ST_EXEC} nab_state_t;

  nab_state_t state;
  nab_pkg::nab_op_t op_q;
  nab_pkg::nab_form_t form_q;
  logic [3:0] tmp_a;
  logic [3:0] tmp_b;
  logic z_flag;
  logic carry_flag;
  logic no_store_flag;
  logic decimal_flag;

  // ***********************************
  // request acceptance and operand pick
  // ***********************************
  wire logic accept;
  wire logic is_rot_in;
  wire logic is_bit_in;
  wire logic [3:0] next_a;
  wire logic [3:0] next_b;
  assign accept = exec_i && (state == ST_IDLE);
  assign is_rot_in = (op_i == nab_pkg::OP_ROT_RIGHT);
  assign is_bit_in = (op_i == nab_pkg::OP_SKIP_ONES) ||
                     (op_i == nab_pkg::OP_SKIP_ZEROS);
  assign next_a = is_rot_in ? gr_data_i :
                  (is_bit_in || form_i == nab_pkg::FORM_MI) ?
                  mem_data_i : gr_data_i;
  assign next_b = is_rot_in ? nab_pkg::NIB_ZERO :
                  (is_bit_in || form_i == nab_pkg::FORM_MI) ?
                  immediate_nibble_i : mem_data_i;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= accept ? ST_EXEC : ST_IDLE;
        ST_EXEC: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tmp_a <= nab_pkg::NIB_ZERO;
      tmp_b <= nab_pkg::NIB_ZERO;
      op_q <= nab_pkg::OP_ADD;
      form_q <= nab_pkg::FORM_RM;
    end else if (accept) begin
      tmp_a <= next_a;
      tmp_b <= next_b;
      op_q <= op_i;
      form_q <= is_rot_in ? nab_pkg::FORM_RM : form_i;
    end
  end

  // ***********************************
  // operation decode
  // ***********************************
  wire logic is_arith;
  wire logic is_sub;
  wire logic use_carry;
  wire logic is_logic;
  wire logic is_bit;
  wire logic is_compare;
  wire logic is_rot;
  assign is_arith = (op_q == nab_pkg::OP_ADD) ||
                    (op_q == nab_pkg::OP_ADD_CARRY) ||
                    (op_q == nab_pkg::OP_SUB) ||
                    (op_q == nab_pkg::OP_SUB_BORROW);
  assign is_sub = (op_q == nab_pkg::OP_SUB) ||
                  (op_q == nab_pkg::OP_SUB_BORROW);
  assign use_carry = (op_q == nab_pkg::OP_ADD_CARRY) ||
                     (op_q == nab_pkg::OP_SUB_BORROW);
  assign is_logic = (op_q == nab_pkg::OP_OR) ||
                    (op_q == nab_pkg::OP_AND) ||
                    (op_q == nab_pkg::OP_XOR);
  assign is_bit = (op_q == nab_pkg::OP_SKIP_ONES) ||
                  (op_q == nab_pkg::OP_SKIP_ZEROS);
  assign is_compare = (op_q == nab_pkg::OP_SKIP_EQ) ||
                      (op_q == nab_pkg::OP_SKIP_NE) ||
                      (op_q == nab_pkg::OP_SKIP_GE) ||
                      (op_q == nab_pkg::OP_SKIP_LT);
  assign is_rot = (op_q == nab_pkg::OP_ROT_RIGHT);

  // ***********************************
  // arithmetic path
  // ***********************************
  wire logic [4:0] cin;
  wire logic [4:0] raw_sum;
  wire logic [4:0] raw_dif;
  assign cin = {4'h0, use_carry & carry_flag};
  // five-bit true result, bit 4 is carry or borrow
  assign raw_sum = {1'b0, tmp_a} + {1'b0, tmp_b} + cin;
  assign raw_dif = {1'b0, tmp_a} - {1'b0, tmp_b} - cin;

  nab_adj_if adj ();
  assign adj.raw = is_sub ? raw_dif : raw_sum;
  assign adj.sub = is_sub;
  assign adj.dec = decimal_flag;

  nab_dec_adjust u_adjust (
    .adj(adj)
  );

  // ***********************************
  // logic, rotate and tests
  // ***********************************
  logic [3:0] logic_res;
  always_comb begin
    case (op_q)
      nab_pkg::OP_OR: logic_res = tmp_a | tmp_b;
      nab_pkg::OP_AND: logic_res = tmp_a & tmp_b;
      default: logic_res = tmp_a ^ tmp_b;
    endcase
  end

  logic test_true;
  always_comb begin
    case (op_q)
      nab_pkg::OP_SKIP_ONES: test_true = ((tmp_a & tmp_b) == tmp_b);
      nab_pkg::OP_SKIP_ZEROS:
        test_true = ((tmp_a & tmp_b) == nab_pkg::NIB_ZERO);
      nab_pkg::OP_SKIP_EQ: test_true = (tmp_a == tmp_b);
      nab_pkg::OP_SKIP_NE: test_true = (tmp_a != tmp_b);
      nab_pkg::OP_SKIP_GE: test_true = (tmp_a >= tmp_b);
      nab_pkg::OP_SKIP_LT: test_true = (tmp_a < tmp_b);
      default: test_true = 1'b0;
    endcase
  end

  wire logic [3:0] rot_res;
  assign rot_res = {carry_flag, tmp_a[3:1]};

  wire logic [3:0] result;
  assign result = is_arith ? adj.res :
                  is_rot ? rot_res : logic_res;

  // ***********************************
  // next flags and write back
  // ***********************************
  wire logic finish;
  wire logic stores;
  wire logic next_z;
  wire logic next_carry;
  wire logic next_no_store;
  wire logic next_bcd;
  assign finish = (state == ST_EXEC);
  // no-store gates storing in both modes
  assign stores = is_logic || is_rot || (is_arith && !no_store_flag);
  assign next_z = !is_arith ? z_flag :
                  (adj.res != nab_pkg::NIB_ZERO) ? 1'b0 :
                  (no_store_flag ? z_flag : 1'b1);
  assign next_carry = is_arith ? adj.carry :
                      is_rot ? tmp_a[0] : carry_flag;
  assign next_no_store = is_bit ? 1'b0 : no_store_flag;
  assign next_bcd = decimal_flag;

  // flags land with the done pulse
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      z_flag <= nab_pkg::RST_Z;
      carry_flag <= nab_pkg::RST_CARRY;
      no_store_flag <= nab_pkg::RST_NO_STORE;
      decimal_flag <= nab_pkg::RST_BCD;
    end else if (finish) begin
      z_flag <= next_z;
      carry_flag <= next_carry;
      no_store_flag <= next_no_store;
      decimal_flag <= next_bcd;
    end else if (psw_wr_i) begin
      z_flag <= psw_wdata_i[nab_pkg::PSW_Z];
      carry_flag <= psw_wdata_i[nab_pkg::PSW_CARRY];
      no_store_flag <= psw_wdata_i[nab_pkg::PSW_NO_STORE];
      decimal_flag <= psw_wdata_i[nab_pkg::PSW_BCD];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      wb_gr_o <= 1'b0;
      wb_mem_o <= 1'b0;
      wb_data_o <= nab_pkg::NIB_ZERO;
      skip_o <= 1'b0;
    end else begin
      done_o <= finish;
      wb_gr_o <= finish && stores && (form_q == nab_pkg::FORM_RM);
      wb_mem_o <= finish && stores && (form_q == nab_pkg::FORM_MI);
      wb_data_o <= finish ? result : wb_data_o;
      skip_o <= finish && (is_bit || is_compare) && test_true;
    end
  end

  always_comb begin
    program_status_word_o = 4'h0;
    program_status_word_o[nab_pkg::PSW_Z] = z_flag;
    program_status_word_o[nab_pkg::PSW_CARRY] = carry_flag;
    program_status_word_o[nab_pkg::PSW_NO_STORE] = no_store_flag;
    program_status_word_o[nab_pkg::PSW_BCD] = decimal_flag;
  end

  // ***********************************
  // assertions
  // ***********************************
  wire logic [4:0] chk_sum;
  assign chk_sum = {1'b0, tmp_a} + {1'b0, tmp_b};

  property p_bin_add;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && op_q == nab_pkg::OP_ADD && !$past(decimal_flag)
    |-> wb_data_o == chk_sum[3:0] && carry_flag == chk_sum[4];
  endproperty
  a_bin_add: assert property (p_bin_add)
    else $error("binary add result or carry wrong");

  property p_dec_add;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && op_q == nab_pkg::OP_ADD && $past(decimal_flag) &&
    chk_sum >= 5'h0a && chk_sum <= 5'h13
    |-> carry_flag && wb_data_o == 4'(chk_sum - 5'h0a);
  endproperty
  a_dec_add: assert property (p_dec_add)
    else $error("decimal add correction wrong");

  property p_no_store;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && is_arith && $past(no_store_flag)
    |-> !wb_gr_o && !wb_mem_o;
  endproperty
  a_no_store: assert property (p_no_store)
    else $error("arithmetic stored under no-store");

  property p_logic_flags;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && is_logic
    |-> carry_flag == $past(carry_flag) && z_flag == $past(z_flag);
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("logic operation changed a flag");

  property p_bit_clear;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && is_bit
    |-> !no_store_flag ##1 (!no_store_flag || $past(psw_wr_i));
  endproperty
  a_bit_clear: assert property (p_bit_clear)
    else $error("bit test left no-store set");

  property p_rotate;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && is_rot
    |-> wb_gr_o && wb_data_o == {$past(carry_flag), tmp_a[3:1]} &&
        carry_flag == tmp_a[0];
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate through carry wrong");

  property p_zero_keep;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && is_arith && $past(no_store_flag) && wb_data_o == 4'h0
    |-> z_flag == $past(z_flag);
  endproperty
  a_zero_keep: assert property (p_zero_keep)
    else $error("zero flag not kept under no-store");

  property p_latency;
    @(posedge mclk_i) disable iff (reset_i)
    accept |=> !done_o ##1 done_o;
  endproperty
  a_latency: assert property (p_latency)
    else $error("done not two cycles after request");

  property p_test_nowb;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && (is_bit || is_compare) |-> !wb_gr_o && !wb_mem_o;
  endproperty
  a_test_nowb: assert property (p_test_nowb)
    else $error("test instruction wrote data");
endmodule // nab_alu
`default_nettype wire

// file: hw/nab_pkg.sv
// Purpose: shared constants and types of the nibble alu
// Assumes: 4-bit data path, one core clock
// Notes: flag reset values and status word bit order live here
package nab_pkg;
  // ***********************************
  // widths and arithmetic constants
  // ***********************************
  localparam int DATA_W = 4;
  localparam logic [4:0] DEC_TEN = 5'h0a;
  localparam logic [4:0] DEC_TWENTY = 5'h14;
  localparam logic [4:0] NIB_MAX = 5'h0f;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  // cycles from an accepted request to its done pulse
  localparam int EXEC_CYCLES = 2;
  // ***********************************
  // status word bit positions
  // ***********************************
  localparam int PSW_Z = 0;
  localparam int PSW_CARRY = 1;
  localparam int PSW_NO_STORE = 2;
  localparam int PSW_BCD = 3;
  // ***********************************
  // flag reset values
  // ***********************************
  localparam logic RST_Z = 1'b0;
  localparam logic RST_CARRY = 1'b0;
  localparam logic RST_NO_STORE = 1'b0;
  localparam logic RST_BCD = 1'b0;
  // ***********************************
  // operations and operand forms
  // ***********************************
  typedef enum logic [3:0] {
    OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW,
    OP_OR, OP_AND, OP_XOR,
    OP_SKIP_ONES, OP_SKIP_ZEROS,
    OP_SKIP_EQ, OP_SKIP_NE, OP_SKIP_GE, OP_SKIP_LT,
    OP_ROT_RIGHT
  } nab_op_t;
  typedef enum logic {FORM_RM, FORM_MI} nab_form_t;
endpackage

// file: hw/nab_adj_if.sv
// Purpose: carries a raw result to the decimal corrector and back
// Assumes: purely combinational path
// Notes: raw is five bits, sum or two's complement difference
`timescale 1ns/1ns
`default_nettype none
interface nab_adj_if;
  logic [4:0] raw;
  logic sub;
  logic dec;
  logic [3:0] res;
  logic carry;
  modport calc (input raw, input sub, input dec, output res, output carry);
  modport user (output raw, output sub, output dec, input res, input carry);
endinterface
`default_nettype wire

// file: hw/nab_dec_adjust.sv
// Purpose: binary or decimal correction of a raw alu result
// Assumes: raw sums 0..31, raw differences -16..15
// Notes: out-of-range decimal codes follow a fixed table
`timescale 1ns/1ns
`default_nettype none
module nab_dec_adjust (
  nab_adj_if.calc adj
);
  // ***********************************
  // correction tables
  // ***********************************
  // returns {carry, nibble}
  // sums ten to thirty-one
  function automatic logic [4:0] add_fix(input logic [4:0] s);
    logic [4:0] t;
    t = s - nab_pkg::DEC_TEN;
    if (s < nab_pkg::DEC_TEN) begin
      add_fix = s;
    end else if (s < nab_pkg::DEC_TWENTY) begin
      add_fix = {1'b1, t[3:0]};
    end else begin
      case (s)
        5'h14, 5'h18: add_fix = 5'h1e;
        5'h15, 5'h19: add_fix = 5'h1f;
        5'h16, 5'h1a, 5'h1e: add_fix = 5'h1c;
        5'h17, 5'h1b, 5'h1f: add_fix = 5'h1d;
        5'h1c: add_fix = 5'h1a;
        default: add_fix = 5'h1b;
      endcase
    end
  endfunction

  function automatic logic [4:0] sub_fix(input logic [4:0] d);
    logic [4:0] t;
    t = d + nab_pkg::DEC_TEN;
    if (d < nab_pkg::DEC_TEN) begin
      sub_fix = d;
    end else if (d >= 5'h16) begin
      sub_fix = {1'b1, t[3:0]};
    end else begin
      case (d)
        5'h0a, 5'h0e, 5'h12: sub_fix = 5'h1c;
        5'h0b, 5'h0f, 5'h13: sub_fix = 5'h1d;
        5'h0c, 5'h10, 5'h14: sub_fix = 5'h1e;
        default: sub_fix = 5'h1f;
      endcase
    end
  endfunction

  // ***********************************
  // selection
  // ***********************************
  wire logic [4:0] fixed;
  assign fixed = !adj.dec ? adj.raw :
                 adj.sub ? sub_fix(adj.raw) : add_fix(adj.raw);
  assign adj.res = fixed[3:0];
  assign adj.carry = fixed[4];
endmodule // nab_dec_adjust
`default_nettype wire

// file: verification/nab_mem_model.sv
// Purpose: register file and data memory places seen by the alu
// Assumes: one register nibble and one memory nibble per request
// Notes: bench preloads both places before each request
`timescale 1ns/1ns
`default_nettype none
module nab_mem_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // bench preload
  input wire logic load_i,
  input wire logic [3:0] load_gr_i,
  input wire logic [3:0] load_mem_i,
  // alu write back
  input wire logic wb_gr_i,
  input wire logic wb_mem_i,
  input wire logic [3:0] wb_data_i,
  // operands
  output logic [3:0] gr_o,
  output logic [3:0] mem_o
);
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      gr_o <= 4'h0;
      mem_o <= 4'h0;
    end else if (load_i) begin
      gr_o <= load_gr_i;
      mem_o <= load_mem_i;
    end else begin
      if (wb_gr_i)
        gr_o <= wb_data_i;
      if (wb_mem_i)
        mem_o <= wb_data_i;
    end
  end
endmodule // nab_mem_model
`default_nettype wire

// file: verification/tb_nibble_alu_binary_decimal.sv
// Purpose: self-checking bench of the nibble alu
// Assumes: one request at a time, at least two cycles apart
// Notes: each request holds exec for a second, refused edge
`timescale 1ns/1ns
`default_nettype none
module tb_nibble_alu_binary_decimal;
  // decimal codes for sums 20..31 and differences 10..15, -16..-11
  localparam logic [3:0] add_hi [12] = '{4'he, 4'hf, 4'hc, 4'hd, 4'he,
    4'hf, 4'hc, 4'hd, 4'ha, 4'hb, 4'hc, 4'hd};
  localparam logic [3:0] sub_hi [6] = '{4'hc, 4'hd, 4'he, 4'hf, 4'hc, 4'hd};
  localparam logic [3:0] sub_lo [6] = '{4'he, 4'hf, 4'hc, 4'hd, 4'he, 4'hf};
  logic mclk_i = 1'b0;
  logic reset_i, exec_i, psw_wr_i, ld, done_o, wb_gr_o, wb_mem_o, skip_o;
  nab_pkg::nab_op_t op_i;
  nab_pkg::nab_form_t form_i;
  logic [3:0] imm, psw_wdata_i, ld_gr, ld_mem, gr_data, mem_data;
  logic [3:0] wb_data_o, psw_o, psw_e;
  int num_errors = 0;
  int n_tests = 0;
  int done_cnt = 0;
  int op_cnt = 0;

  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (done_o === 1'b1)
      done_cnt++;
  end

  nab_alu i_nab_alu (.mclk_i(mclk_i), .reset_i(reset_i), .exec_i(exec_i),
    .op_i(op_i), .form_i(form_i), .gr_data_i(gr_data),
    .mem_data_i(mem_data), .immediate_nibble_i(imm), .psw_wr_i(psw_wr_i),
    .psw_wdata_i(psw_wdata_i), .done_o(done_o), .wb_gr_o(wb_gr_o),
    .wb_mem_o(wb_mem_o), .wb_data_o(wb_data_o), .skip_o(skip_o),
    .program_status_word_o(psw_o));
  nab_mem_model i_nab_mem_model (.mclk_i(mclk_i), .reset_i(reset_i),
    .load_i(ld), .load_gr_i(ld_gr), .load_mem_i(ld_mem),
    .wb_gr_i(wb_gr_o), .wb_mem_i(wb_mem_o), .wb_data_i(wb_data_o),
    .gr_o(gr_data), .mem_o(mem_data));

  // ****************************
  // shared tasks
  // ****************************
  task automatic check(input string what, input logic [3:0] seen,
      input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic set_psw(input logic [3:0] v);
    @(negedge mclk_i);
    psw_wr_i = 1'b1;
    psw_wdata_i = v;
    @(negedge mclk_i);
    psw_wr_i = 1'b0;
    psw_e = v;
    check("status write", psw_o, v);
  endtask

  task automatic run_op(input nab_pkg::nab_op_t op,
      input nab_pkg::nab_form_t fm, input logic [3:0] gr,
      input logic [3:0] mem, input logic [3:0] im);
    logic [3:0] a, b, res, gr_e, mem_e;
    logic wr, skp, cyo, bit_op, add, tgr;
    int v, cin, i;
    bit_op = op inside {nab_pkg::OP_SKIP_ONES, nab_pkg::OP_SKIP_ZEROS};
    a = (fm == nab_pkg::FORM_MI || bit_op) ? mem : gr;
    b = (fm == nab_pkg::FORM_MI || bit_op) ? im : mem;
    add = op inside {nab_pkg::OP_ADD, nab_pkg::OP_ADD_CARRY};
    cin = (op inside {nab_pkg::OP_ADD_CARRY, nab_pkg::OP_SUB_BORROW}) ?
      int'(psw_e[nab_pkg::PSW_CARRY]) : 0;
    res = a;
    wr = 1'b1;
    skp = 1'b0;
    case (op)
      nab_pkg::OP_ADD, nab_pkg::OP_ADD_CARRY, nab_pkg::OP_SUB,
      nab_pkg::OP_SUB_BORROW: begin
        v = add ? int'(a) + int'(b) + cin : int'(a) - int'(b) - cin;
        res = v[3:0];
        cyo = (v < 0 || v > 15);
        if (psw_e[nab_pkg::PSW_BCD]) begin
          cyo = (v < 0 || v > 9);
          if (v >= 20)
            res = add_hi[v - 20];
          else if (v >= 10)
            res = add ? 4'(v - 10) : sub_hi[v - 10];
          else if (v < -10)
            res = sub_lo[v + 16];
          else if (v < 0)
            res = 4'(v + 10);
        end
        wr = !psw_e[nab_pkg::PSW_NO_STORE];
        psw_e[nab_pkg::PSW_Z] = (res != 4'h0) ? 1'b0 :
          (psw_e[nab_pkg::PSW_NO_STORE] ? psw_e[nab_pkg::PSW_Z] : 1'b1);
        psw_e[nab_pkg::PSW_CARRY] = cyo;
      end
      nab_pkg::OP_OR: res = a | b;
      nab_pkg::OP_AND: res = a & b;
      nab_pkg::OP_XOR: res = a ^ b;
      nab_pkg::OP_ROT_RIGHT: begin
        res = {psw_e[nab_pkg::PSW_CARRY], a[3:1]};
        psw_e[nab_pkg::PSW_CARRY] = a[0];
      end
      nab_pkg::OP_SKIP_ONES, nab_pkg::OP_SKIP_ZEROS: begin
        wr = 1'b0;
        skp = (op == nab_pkg::OP_SKIP_ONES) ? ((a & b) == b) :
          ((a & b) == 4'h0);
        psw_e[nab_pkg::PSW_NO_STORE] = 1'b0;
      end
      default: begin
        wr = 1'b0;
        skp = (op == nab_pkg::OP_SKIP_EQ) ? a == b :
          (op == nab_pkg::OP_SKIP_NE) ? a != b :
          (op == nab_pkg::OP_SKIP_GE) ? a >= b : a < b;
      end
    endcase
    tgr = (fm == nab_pkg::FORM_RM || op == nab_pkg::OP_ROT_RIGHT);
    gr_e = (wr && tgr) ? res : gr;
    mem_e = (wr && !tgr) ? res : mem;
    @(negedge mclk_i);
    ld = 1'b1;
    ld_gr = gr;
    ld_mem = mem;
    @(negedge mclk_i);
    ld = 1'b0;
    exec_i = 1'b1;
    op_i = op;
    form_i = fm;
    imm = im;
    // the second edge with exec high must be refused
    @(negedge mclk_i);
    @(negedge mclk_i);
    exec_i = 1'b0;
    op_cnt++;
    for (i = 0; i < 6 && done_o !== 1'b1; i++)
      @(negedge mclk_i);
    if (done_o !== 1'b1) begin
      num_errors++;
      $display("unexpected done: expected 1 seen %b", done_o);
      finish_test();
    end
    check("latency", 4'(i), 4'h0);
    if (op <= nab_pkg::OP_XOR || op == nab_pkg::OP_ROT_RIGHT)
      check("result", wb_data_o, res);
    check("skip", skip_o, skp);
    check("status", psw_o, psw_e);
    check("wb pulses", {wb_gr_o, wb_mem_o}, {wr && tgr, wr && !tgr});
    @(negedge mclk_i);
    check("register", gr_data, gr_e);
    check("memory", mem_data, mem_e);
  endtask

  // ****************************
  // main sequence
  // ****************************
  initial begin
    int m, o, x, k;
    logic [3:0] a, b;
    reset_i = 1'b1;
    exec_i = 1'b0;
    op_i = nab_pkg::OP_ADD;
    form_i = nab_pkg::FORM_RM;
    imm = 4'h0;
    psw_wr_i = 1'b0;
    psw_wdata_i = 4'h0;
    ld = 1'b0;
    ld_gr = 4'h0;
    ld_mem = 4'h0;
    repeat (2) @(negedge mclk_i);
    reset_i = 1'b0;
    psw_e = 4'h0;
    check("reset status", psw_o, 4'h0);
    // every operand pair and mode of the four arithmetic ops, carry-in taken from a[0] xor b[0]
    for (m = 0; m < 4; m++) begin
      for (o = 0; o < 4; o++) begin
        for (x = 0; x < 256; x++) begin
          a = x[7:4];
          b = x[3:0];
          set_psw({m[1:0], a[0] ^ b[0], b[3]});
          if (b[1])
            run_op(nab_pkg::nab_op_t'(o), nab_pkg::FORM_MI, ~a, a, b);
          else
            run_op(nab_pkg::nab_op_t'(o), nab_pkg::FORM_RM, a, b, ~b);
        end
      end
    end
    $display("test arithmetic done");
    for (x = 0; x < 48; x++) begin
      set_psw(x[3:0]);
      run_op(nab_pkg::nab_op_t'(4 + x / 16), nab_pkg::nab_form_t'(x[0]),
        x[3:0], 4'(x * 5), 4'(x * 3));
    end
    $display("test logic done");
    for (k = 0; k < 4; k++) begin
      set_psw(4'h4 | 4'(k));
      run_op(k < 2 ? nab_pkg::OP_SKIP_ONES : nab_pkg::OP_SKIP_ZEROS,
        nab_pkg::FORM_RM, 4'h0, k < 2 ? 4'hb : 4'h9,
        k == 2 ? 4'h6 : k[0] ? 4'he : 4'hb);
    end
    $display("test bit evaluation done");
    for (o = 9; o < 13; o++) begin
      for (k = 0; k < 3; k++) begin
        set_psw(4'(o));
        run_op(nab_pkg::nab_op_t'(o), nab_pkg::FORM_RM, 4'(5 + 4 * (k == 1)),
          4'(5 + 4 * (k == 2)), 4'h0);
      end
    end
    $display("test comparison done");
    for (x = 0; x < 32; x++) begin
      set_psw(4'(x));
      run_op(nab_pkg::OP_ROT_RIGHT, nab_pkg::FORM_RM, 4'(x * 7), 4'(x),
        4'h0);
    end
    $display("test rotation done");
    check("done count", done_cnt == op_cnt, 4'h1);
    finish_test();
  end
endmodule // tb_nibble_alu_binary_decimal
`default_nettype wire
